// >>> rtl/dacuc_pkg.sv
// package: register map, field positions and reset values of the dac update control
package dacuc_pkg;
    // ************************************************
    // register byte addresses
    // ************************************************
    localparam logic [3:0] DACUC_ADR_CONTROL   = 4'h0;
    localparam logic [3:0] DACUC_ADR_LOW_BYTE  = 4'h4;
    localparam logic [3:0] DACUC_ADR_HIGH_BYTE = 4'h8;
    localparam logic [3:0] DACUC_ADR_STATUS    = 4'hC;
    // ************************************************
    // control field positions
    // ************************************************
    localparam int DACUC_BIT_ENABLE     = 0;
    localparam int DACUC_BIT_PIN_OE     = 1;
    localparam int DACUC_BIT_LEFT_ALIGN = 2;
    localparam int DACUC_BIT_SEL_LO     = 4;
    localparam int DACUC_BIT_AUTO_TRIG  = 7;
    localparam logic [7:0] DACUC_CONTROL_MASK = 8'hF7;
    // ************************************************
    // widths and reset values
    // ************************************************
    localparam int DACUC_CODE_W = 10;
    localparam int DACUC_NUM_TRIG = 8;
    localparam logic [7:0] DACUC_RST_BYTE = 8'h00;
    localparam logic [9:0] DACUC_RST_CODE = 10'h000;
    localparam logic [3:0] DACUC_CONV_CYCLES = 4'h4;
endpackage

// >>> rtl/dacuc_top.sv
// dac update control: register slave, trigger edge detect and holding register
// How it works
// - converter runs only while enable bit set
// - auto mode loads on selected trigger edge
// - manual mode loads on high byte write
// - three-bit field selects one of eight triggers
// - trigger is raw flag rising edge, unmasked
// - edges during conversion ignored, no relaunch
// - fresh rising edge needed; software clears flag
// - low byte write blocks load until high
// - align bit selects left or right split
// - align change acts from next high write
// - pin enable routes result to output pin only while enable bit set
// - left aligned high write alone updates
// - holding register and input are ten bits
// - hidden holding register; documented byte split
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module dacuc_top
    import dacuc_pkg::*;
#(
    parameter int CONV_CYCLES = 4
) (
    // system
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // wishbone slave
    input  wire logic                          cyc_i,
    input  wire logic                          stb_i,
    input  wire logic                          we_i,
    input  wire logic [3:0]                    adr_i,
    input  wire logic [3:0]                    sel_i,
    input  wire logic [31:0]                   dat_i,
    output logic      [31:0]                   dat_o,
    output logic                               ack_o,
    // trigger source flags
    input  wire logic [dacuc_pkg::DACUC_NUM_TRIG-1:0] trig_flags_i,
    // analog core
    output logic      [dacuc_pkg::DACUC_CODE_W-1:0]   code_o,
    output logic                               core_enable_o,
    output logic                               analog_out_pin_enable_o,
    output logic                               convert_o
);
    import dacuc_pkg::*;

    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        logic [7:0]  dac_control;
        logic [7:0]  input_low_byte;
        logic [7:0]  input_high_byte;
        logic        low_pending;
        logic        align_at_high;
        logic        trig_prev;
        logic [3:0]  conv_cnt;
        logic [9:0]  code;
        logic        convert;
        logic        ack;
        logic [31:0] rdata;
    } dacuc_state_t;

    dacuc_state_t st_r;
    dacuc_state_t st_nxt;

    logic       req;
    logic       wr_ctl;
    logic       wr_low;
    logic       wr_high;
    logic       trig_sel;
    logic       trig_edge;
    logic       busy;
    logic       load;
    logic [9:0] new_code;
    logic [7:0] low_w;
    logic [7:0] high_w;
    logic       left_now;

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        st_nxt   = st_r;
        req      = cyc_i && stb_i && !st_r.ack;
        wr_ctl   = req && we_i && sel_i[0] && (adr_i == DACUC_ADR_CONTROL);
        wr_low   = req && we_i && sel_i[0] && (adr_i == DACUC_ADR_LOW_BYTE);
        wr_high  = req && we_i && sel_i[0] && (adr_i == DACUC_ADR_HIGH_BYTE);
        left_now = st_r.dac_control[DACUC_BIT_LEFT_ALIGN];
        // unused bits forced to zero on write
        low_w    = left_now ? (dat_i[7:0] & 8'hC0) : dat_i[7:0];
        high_w   = left_now ? dat_i[7:0] : (dat_i[7:0] & 8'h03);
        st_nxt.ack = req;
        st_nxt.rdata = 32'h0000_0000;
        if (req && !we_i) begin
            if (adr_i == DACUC_ADR_CONTROL) begin
                st_nxt.rdata = {24'h00_0000, st_r.dac_control};
            end else if (adr_i == DACUC_ADR_LOW_BYTE) begin
                st_nxt.rdata = {24'h00_0000, st_r.input_low_byte};
            end else if (adr_i == DACUC_ADR_HIGH_BYTE) begin
                st_nxt.rdata = {24'h00_0000, st_r.input_high_byte};
            end else if (adr_i == DACUC_ADR_STATUS) begin
                st_nxt.rdata = {28'h000_0000, st_r.convert, busy, st_r.low_pending, st_r.align_at_high};
            end else begin
                st_nxt.rdata = 32'h0000_0000;
            end
        end
        if (wr_ctl) begin
            st_nxt.dac_control = dat_i[7:0] & DACUC_CONTROL_MASK;
        end
        if (wr_low) begin
            st_nxt.input_low_byte = low_w;
            st_nxt.low_pending    = 1'b1;
        end
        if (wr_high) begin
            st_nxt.input_high_byte = high_w;
            st_nxt.low_pending     = 1'b0;
            st_nxt.align_at_high   = left_now;
        end
        // trigger: raw flag edge of selected source
        trig_sel  = trig_flags_i[st_r.dac_control[DACUC_BIT_AUTO_TRIG-1:DACUC_BIT_SEL_LO]];
        trig_edge = trig_sel && !st_r.trig_prev;
        st_nxt.trig_prev = trig_sel;
        busy = (st_r.conv_cnt != 4'h0);
        // choose load source
        if (st_r.dac_control[DACUC_BIT_AUTO_TRIG]) begin
            load = trig_edge && !busy && !st_r.low_pending;
        end else begin
            load = wr_high;
        end
        // split per alignment latched at last high write
        if (st_r.dac_control[DACUC_BIT_AUTO_TRIG]) begin
            new_code = st_r.align_at_high ? {st_r.input_high_byte, st_r.input_low_byte[7:6]}
                                          : {st_r.input_high_byte[1:0], st_r.input_low_byte};
        end else begin
            new_code = left_now ? {high_w, st_r.input_low_byte[7:6]}
                                : {high_w[1:0], st_r.input_low_byte};
        end
        st_nxt.convert = 1'b0;
        if (busy) begin
            st_nxt.conv_cnt = st_r.conv_cnt - 4'h1;
        end
        if (load) begin
            st_nxt.code = new_code;
            if (st_r.dac_control[DACUC_BIT_ENABLE]) begin
                st_nxt.convert  = 1'b1;
                st_nxt.conv_cnt = 4'(CONV_CYCLES);
            end
        end
        if (!st_r.dac_control[DACUC_BIT_ENABLE]) begin
            st_nxt.conv_cnt = 4'h0;
        end
    end

    // ************************************************
    // registers
    // ************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dat_o                   = st_r.rdata;
    assign ack_o                   = st_r.ack;
    assign code_o                  = st_r.code;
    assign core_enable_o           = st_r.dac_control[DACUC_BIT_ENABLE];
    assign analog_out_pin_enable_o = st_r.dac_control[DACUC_BIT_ENABLE] && st_r.dac_control[DACUC_BIT_PIN_OE];
    assign convert_o               = st_r.convert;

    // ************************************************
    // assertions
    // ************************************************
    AST_DISABLED_NO_CONVERT: assert property (@(posedge clk_i) disable iff (rst_i)
        convert_o |-> core_enable_o) else $error("conversion while disabled");
    AST_AUTO_EDGE_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.dac_control[7] && st_r.dac_control[0] && trig_edge && !busy && !st_r.low_pending)
        |=> convert_o) else $error("trigger edge did not launch");
    AST_MANUAL_HIGH_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
        (!st_r.dac_control[7] && wr_high) |=> (code_o == $past(new_code))) else $error("high write no load");
    AST_BUSY_IGNORE: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.dac_control[7] && busy) |=> !convert_o) else $error("edge taken during conversion");
    AST_NO_LEVEL_RETRIGGER: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.dac_control[7] && st_r.trig_prev) |-> !load) else $error("level retrigger");
    AST_LOW_BLOCKS: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r.dac_control[7] && st_r.low_pending) |=> $stable(code_o)) else $error("load while low pending");
    AST_PIN_ROUTE: assert property (@(posedge clk_i) disable iff (rst_i)
        analog_out_pin_enable_o |-> st_r.dac_control[1]) else $error("pin driven while off");
    AST_RESERVED_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
        st_r.dac_control[3] == 1'b0 ##1 st_r.dac_control[3] == 1'b0) else $error("reserved bit set");
    AST_ACK_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o) else $error("ack longer than one cycle");
    COV_AUTO_LOAD: cover property (@(posedge clk_i) disable iff (rst_i) st_r.dac_control[7] && load);
    COV_MANUAL_LOAD: cover property (@(posedge clk_i) disable iff (rst_i) !st_r.dac_control[7] && load);
    COV_BUSY_EDGE: cover property (@(posedge clk_i) disable iff (rst_i) busy && trig_edge);
    COV_LEFT_HIGH: cover property (@(posedge clk_i) disable iff (rst_i) wr_high && left_now);

endmodule // dacuc_top

// >>> testbench/dacuc_flag_model.sv
// trigger flag sources: event flags set by hardware, cleared by software
`timescale 1ns/1ps
module dacuc_flag_model (
    // system
    input  wire logic       clk_i,
    // flags to the block
    output logic      [7:0] flags_o
);
    // ************************************************
    // flag event then software clear
    // ************************************************
    initial flags_o = 8'h00;
    task automatic pulse_flag(input int idx);
        @(posedge clk_i);
        flags_o[idx] <= 1'b1;
        @(posedge clk_i);
        flags_o[idx] <= 1'b0;
    endtask
endmodule // dacuc_flag_model

// >>> testbench/testbench.sv
// testbench for the dac update control
`timescale 1ns/1ps
module testbench;
    import dacuc_pkg::*;
    logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [3:0]  adr_i = 4'h0, sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic        ack_o, core_enable_o, analog_out_pin_enable_o, convert_o;
    logic [7:0]  trig_flags_i;
    logic [9:0]  code_o, prev;
    int          mismatches = 0, checks = 0, conv_cnt = 0, c0;
    dacuc_top #(.CONV_CYCLES(4)) dacuc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .trig_flags_i(trig_flags_i), .code_o(code_o), .core_enable_o(core_enable_o),
        .analog_out_pin_enable_o(analog_out_pin_enable_o), .convert_o(convert_o));
    dacuc_flag_model dacuc_flag_model_inst (.clk_i(clk_i), .flags_o(trig_flags_i));
    // ************************************************
    // clock, pulse counter, bus tasks
    // ************************************************
    initial forever #5 clk_i = ~clk_i;
    always @(negedge clk_i) if (convert_o === 1'b1) conv_cnt++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= {24'h000000, d};
        do begin
            @(negedge clk_i);
            q = dat_o;
        end while (ack_o !== 1'b1);
        @(posedge clk_i);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask
    task automatic trig(input int idx);
        dacuc_flag_model_inst.pulse_flag(idx);
        repeat (6) @(posedge clk_i);
    endtask
    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_manual();
        rd(DACUC_ADR_CONTROL, 32'h0);
        wr(DACUC_ADR_CONTROL, 8'h0B);
        rd(DACUC_ADR_CONTROL, 32'h03);
        wr(DACUC_ADR_LOW_BYTE, 8'hAB);
        chk(code_o, 10'h000);
        wr(DACUC_ADR_HIGH_BYTE, 8'hFF);
        chk(code_o, 10'h3AB);
        chk(conv_cnt, 1);
        chk(analog_out_pin_enable_o, 1'b1);
        rd(DACUC_ADR_HIGH_BYTE, 32'h03);
    endtask
    task automatic t_left();
        wr(DACUC_ADR_CONTROL, 8'h05);
        chk(code_o, 10'h3AB);
        chk(analog_out_pin_enable_o, 1'b0);
        wr(DACUC_ADR_HIGH_BYTE, 8'h80);
        chk(code_o, 10'h202);
        wr(DACUC_ADR_CONTROL, 8'h04);
        wr(DACUC_ADR_HIGH_BYTE, 8'h11);
        chk(code_o, 10'h046);
        chk({core_enable_o, conv_cnt[3:0]}, 5'h02);
    endtask
    task automatic t_sources();
        prev = 10'h046;
        for (int s = 0; s < 8; s++) begin
            wr(DACUC_ADR_CONTROL, 8'h85 | 8'(s << 4));
            wr(DACUC_ADR_HIGH_BYTE, 8'(s + 1));
            chk(code_o, prev);
            trig((s + 1) % 8);
            chk(code_o, prev);
            trig(s);
            prev = {8'(s + 1), 2'b10};
            chk(code_o, prev);
        end
    endtask
    task automatic t_busy();
        wr(DACUC_ADR_CONTROL, 8'h85);
        wr(DACUC_ADR_HIGH_BYTE, 8'h40);
        c0 = conv_cnt;
        dacuc_flag_model_inst.pulse_flag(0);
        trig(0);
        chk(conv_cnt, c0 + 1);
        chk(code_o, 10'h102);
        trig(0);
        chk(conv_cnt, c0 + 2);
        wr(DACUC_ADR_LOW_BYTE, 8'h40);
        trig(0);
        chk(code_o, 10'h102);
        wr(DACUC_ADR_HIGH_BYTE, 8'h40);
        trig(0);
        chk(code_o, 10'h101);
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        chk(code_o, 10'h000);
        t_manual();
        t_left();
        t_sources();
        t_busy();
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        test_done();
    end
endmodule // testbench
